// ### common/scpi_status_pkg.sv
// constants and types shared by the status reporting block
package scpi_status_pkg;
	localparam int QUES_W = 16;
	localparam int ESR_W = 8;
	localparam int STB_W = 8;
	localparam int RESP_W = 16;
	localparam int COND_W = 4;

	// questionable data condition bit positions
	localparam int QUES_OVLD_BIT = 0;
	localparam int QUES_UNLOCK_BIT = 5;
	localparam int QUES_CAL_BIT = 8;
	localparam int QUES_EXTREF_BIT = 9;
	localparam logic [15:0] QUES_VALID = 16'h0321;
	localparam logic [15:0] QUES_EVENT_RESET = 16'h0000;
	localparam logic [15:0] QUES_ENABLE_RESET = 16'h0000;

	// standard event bit positions
	localparam int ESR_OPC_BIT = 0;
	localparam int ESR_QUERY_BIT = 2;
	localparam int ESR_DEVICE_BIT = 3;
	localparam int ESR_EXEC_BIT = 4;
	localparam int ESR_CMD_BIT = 5;
	localparam int ESR_PON_BIT = 7;
	localparam logic [7:0] ESR_VALID = 8'hbd;
	localparam logic [7:0] ESR_EVENT_RESET = 8'h80;
	localparam logic [7:0] ESR_ENABLE_RESET = 8'h00;

	// status byte bit positions
	localparam int STB_ERRQ_BIT = 2;
	localparam int STB_QUES_BIT = 3;
	localparam int STB_MAV_BIT = 4;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_MSS_BIT = 6;
	localparam logic [7:0] SRE_VALID = 8'h3c;
	localparam logic [7:0] SRE_RESET = 8'h00;
	localparam logic PSC_RESET = 1'b1;

	// query codes
	localparam logic [2:0] QRY_STB = 3'h0;
	localparam logic [2:0] QRY_SRE = 3'h1;
	localparam logic [2:0] QRY_ESR = 3'h2;
	localparam logic [2:0] QRY_ESE = 3'h3;
	localparam logic [2:0] QRY_QCOND = 3'h4;
	localparam logic [2:0] QRY_QEVENT = 3'h5;
	localparam logic [2:0] QRY_QENAB = 3'h6;
	localparam logic [2:0] QRY_PSC = 3'h7;

	// write codes
	localparam logic [1:0] WR_SRE = 2'h0;
	localparam logic [1:0] WR_ESE = 2'h1;
	localparam logic [1:0] WR_QENAB = 2'h2;
	localparam logic [1:0] WR_PSC = 2'h3;

	typedef enum logic {Q_IDLE, Q_WAIT_DONE} qry_state_t;
endpackage : scpi_status_pkg

// ### core/status_event_group.sv
// event and enable layers of one status register group
`timescale 1ns/100ps
module status_event_group #(
	parameter int W = 8,
	parameter logic [W-1:0] VALID = '1,
	parameter logic [W-1:0] EVENT_RESET = '0,
	parameter logic [W-1:0] ENABLE_RESET = '0
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [W-1:0] set_bits,
	input wire logic clear_events,
	input wire logic enable_wr,
	input wire logic [W-1:0] enable_data,
	input wire logic enable_clear,
	output logic [W-1:0] event_bits,
	output logic [W-1:0] enable_bits,
	output logic summary
);
	typedef struct packed {
		logic [W-1:0] events;
		logic [W-1:0] enable;
	} group_state_t;

	group_state_t state;
	group_state_t next_state;

	always_comb
	begin
		next_state = state;
		// set wins over a clear in the same cycle
		next_state.events = ((state.events & ~{W{clear_events}}) | set_bits)
			& VALID;
		if (enable_clear)
		begin
			next_state.enable = '0;
		end
		else if (enable_wr)
		begin
			next_state.enable = enable_data & VALID;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state.events <= EVENT_RESET;
			state.enable <= ENABLE_RESET;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign event_bits = state.events;
	assign enable_bits = state.enable;
	assign summary = |(state.events & state.enable);
endmodule : status_event_group

// ### core/status_srq_unit.sv
// service request line and serial poll answer
`timescale 1ns/100ps
module status_srq_unit (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] summary_bits,
	input wire logic [7:0] sre,
	input wire logic poll_strobe,
	output logic mss,
	output logic rqs,
	output logic [7:0] poll_byte,
	output logic poll_valid,
	output logic srq_oe
);
	typedef struct packed {
		logic mss_prev;
		logic rqs;
		logic [7:0] poll_byte;
		logic poll_valid;
		logic srq_oe;
	} srq_state_t;

	srq_state_t state;
	srq_state_t next_state;
	logic mss_now;

	assign mss_now = |(summary_bits & sre & scpi_status_pkg::SRE_VALID);

	always_comb
	begin
		next_state = state;
		next_state.mss_prev = mss_now;
		next_state.poll_valid = poll_strobe;
		if (poll_strobe)
		begin
			next_state.poll_byte = summary_bits;
			next_state.poll_byte[scpi_status_pkg::STB_MSS_BIT] = state.rqs;
		end
		// a fresh rise of the summary beats the clear by a poll
		next_state.rqs = (state.rqs & ~poll_strobe)
			| (mss_now & ~state.mss_prev);
		next_state.srq_oe = next_state.rqs;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign mss = mss_now;
	assign rqs = state.rqs;
	assign poll_byte = state.poll_byte;
	assign poll_valid = state.poll_valid;
	assign srq_oe = state.srq_oe;
endmodule : status_srq_unit

// ### core/scpi_status_reporting.sv
// status byte, event groups, queries and serial poll of the instrument
`timescale 1ns/100ps
module scpi_status_reporting (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic volt_overload,
	input wire logic pll_unlocked,
	input wire logic cal_fault,
	input wire logic ext_ref_used,
	input wire logic spoll_active,
	input wire logic err_queue_nonempty,
	input wire logic out_pending,
	input wire logic cmds_done,
	input wire logic ops_done,
	input wire logic qerr_empty_read,
	input wire logic qerr_interrupted,
	input wire logic qerr_buffers_full,
	input wire logic err_device,
	input wire logic err_exec,
	input wire logic err_command,
	input wire logic cmd_cls,
	input wire logic cmd_preset,
	input wire logic cmd_opc,
	input wire logic wr_valid,
	input wire logic [1:0] wr_code,
	input wire logic [15:0] wr_data,
	input wire logic qry_valid,
	input wire logic [2:0] qry_code,
	output logic qry_ready,
	output logic resp_valid,
	output logic [15:0] resp_data,
	output logic [7:0] status_byte,
	output logic opc_pending,
	output logic [7:0] poll_byte,
	output logic poll_valid,
	output logic srq_out,
	output logic srq_oe
);
	typedef struct packed {
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic [3:0] cond_prev;
		logic spoll_prev;
		logic opc_armed;
		logic psc;
		logic [7:0] sre;
		logic [7:0] stb;
		scpi_status_pkg::qry_state_t qstate;
		logic qry_ready;
		logic resp_valid;
		logic [15:0] resp_data;
	} top_state_t;

	top_state_t state;
	top_state_t next_state;

	logic [3:0] cond_now;
	logic [15:0] ques_cond;
	logic [15:0] ques_rise;
	logic [15:0] ques_events;
	logic [15:0] ques_enable;
	logic ques_summary;
	logic [7:0] esr_set;
	logic [7:0] esr_events;
	logic [7:0] esr_enable;
	logic esr_summary;
	logic [7:0] stb_low;
	logic [7:0] stb_full;
	logic mss;
	logic poll_strobe;
	logic take_qry;
	logic clr_ques;
	logic clr_esr;
	logic ques_en_wr;
	logic ques_en_clr;
	logic ese_wr;
	logic opc_fire;

	// map synchronised conditions onto the 16-bit questionable layout
	function automatic logic [15:0] ques_map(input logic [3:0] c);
		logic [15:0] m;
		m = '0;
		m[scpi_status_pkg::QUES_OVLD_BIT] = c[0];
		m[scpi_status_pkg::QUES_UNLOCK_BIT] = c[1];
		m[scpi_status_pkg::QUES_CAL_BIT] = c[2];
		m[scpi_status_pkg::QUES_EXTREF_BIT] = c[3];
		return m;
	endfunction : ques_map

	assign cond_now = state.sync2[3:0];
	assign ques_cond = ques_map(cond_now);
	assign ques_rise = ques_map(cond_now & ~state.cond_prev);
	assign poll_strobe = state.sync2[4] & ~state.spoll_prev;

	assign take_qry = qry_valid & state.qry_ready;
	assign clr_ques = cmd_cls
		| (take_qry & (qry_code == scpi_status_pkg::QRY_QEVENT));
	assign clr_esr = cmd_cls
		| (take_qry & (qry_code == scpi_status_pkg::QRY_ESR));
	assign ques_en_wr = wr_valid & (wr_code == scpi_status_pkg::WR_QENAB);
	assign ques_en_clr = cmd_preset
		| (ques_en_wr & (wr_data == 16'h0000));
	assign ese_wr = wr_valid & (wr_code == scpi_status_pkg::WR_ESE);

	assign opc_fire = state.opc_armed & ops_done & ~cmd_cls;

	always_comb
	begin
		esr_set = '0;
		esr_set[scpi_status_pkg::ESR_OPC_BIT] = opc_fire;
		esr_set[scpi_status_pkg::ESR_QUERY_BIT] = qerr_empty_read
			| qerr_interrupted | qerr_buffers_full;
		esr_set[scpi_status_pkg::ESR_DEVICE_BIT] = err_device;
		esr_set[scpi_status_pkg::ESR_EXEC_BIT] = err_exec;
		esr_set[scpi_status_pkg::ESR_CMD_BIT] = err_command;
	end

	always_comb
	begin
		stb_low = '0;
		stb_low[scpi_status_pkg::STB_ERRQ_BIT] = err_queue_nonempty;
		stb_low[scpi_status_pkg::STB_QUES_BIT] = ques_summary;
		stb_low[scpi_status_pkg::STB_MAV_BIT] = out_pending;
		stb_low[scpi_status_pkg::STB_ESB_BIT] = esr_summary;
		stb_full = stb_low;
		stb_full[scpi_status_pkg::STB_MSS_BIT] = mss;
	end

	status_event_group #(
		.W(scpi_status_pkg::QUES_W),
		.VALID(scpi_status_pkg::QUES_VALID),
		.EVENT_RESET(scpi_status_pkg::QUES_EVENT_RESET),
		.ENABLE_RESET(scpi_status_pkg::QUES_ENABLE_RESET)
	) u_ques_group (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.set_bits(ques_rise),
		.clear_events(clr_ques),
		.enable_wr(ques_en_wr),
		.enable_data(wr_data),
		.enable_clear(ques_en_clr),
		.event_bits(ques_events),
		.enable_bits(ques_enable),
		.summary(ques_summary)
	);

	status_event_group #(
		.W(scpi_status_pkg::ESR_W),
		.VALID(scpi_status_pkg::ESR_VALID),
		.EVENT_RESET(scpi_status_pkg::ESR_EVENT_RESET),
		.ENABLE_RESET(scpi_status_pkg::ESR_ENABLE_RESET)
	) u_esr_group (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.set_bits(esr_set),
		.clear_events(clr_esr),
		.enable_wr(ese_wr),
		.enable_data(wr_data[7:0]),
		.enable_clear(1'b0),
		.event_bits(esr_events),
		.enable_bits(esr_enable),
		.summary(esr_summary)
	);

	status_srq_unit u_srq (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.summary_bits(stb_low),
		.sre(state.sre),
		.poll_strobe(poll_strobe),
		.mss(mss),
		.rqs(),
		.poll_byte(poll_byte),
		.poll_valid(poll_valid),
		.srq_oe(srq_oe)
	);

	always_comb
	begin
		next_state = state;
		next_state.sync1 = {spoll_active, ext_ref_used, cal_fault,
			pll_unlocked, volt_overload};
		next_state.sync2 = state.sync1;
		next_state.cond_prev = cond_now;
		next_state.spoll_prev = state.sync2[4];
		next_state.stb = stb_full;
		next_state.resp_valid = 1'b0;
		if (cmd_opc)
		begin
			next_state.opc_armed = 1'b1;
		end
		else if (opc_fire || cmd_cls)
		begin
			next_state.opc_armed = 1'b0;
		end
		if (wr_valid && wr_code == scpi_status_pkg::WR_SRE)
		begin
			next_state.sre = wr_data[7:0] & scpi_status_pkg::SRE_VALID;
		end
		if (wr_valid && wr_code == scpi_status_pkg::WR_PSC)
		begin
			next_state.psc = wr_data[0];
		end
		case (state.qstate)
			scpi_status_pkg::Q_IDLE:
			begin
				if (take_qry)
				begin
					case (qry_code)
						scpi_status_pkg::QRY_STB:
						begin
							next_state.qstate = scpi_status_pkg::Q_WAIT_DONE;
							next_state.qry_ready = 1'b0;
						end
						scpi_status_pkg::QRY_SRE:
						begin
							next_state.resp_valid = 1'b1;
							next_state.resp_data = {8'h00, state.sre};
						end
						scpi_status_pkg::QRY_ESR:
						begin
							next_state.resp_valid = 1'b1;
							next_state.resp_data = {8'h00, esr_events};
						end
						scpi_status_pkg::QRY_ESE:
						begin
							next_state.resp_valid = 1'b1;
							next_state.resp_data = {8'h00, esr_enable};
						end
						scpi_status_pkg::QRY_QCOND:
						begin
							next_state.resp_valid = 1'b1;
							next_state.resp_data = ques_cond;
						end
						scpi_status_pkg::QRY_QEVENT:
						begin
							next_state.resp_valid = 1'b1;
							next_state.resp_data = ques_events;
						end
						scpi_status_pkg::QRY_QENAB:
						begin
							next_state.resp_valid = 1'b1;
							next_state.resp_data = ques_enable;
						end
						default:
						begin
							next_state.resp_valid = 1'b1;
							next_state.resp_data = {15'h0000, state.psc};
						end
					endcase
				end
			end
			scpi_status_pkg::Q_WAIT_DONE:
			begin
				if (cmds_done)
				begin
					next_state.resp_valid = 1'b1;
					next_state.resp_data = {8'h00, stb_full};
					next_state.qstate = scpi_status_pkg::Q_IDLE;
					next_state.qry_ready = 1'b1;
				end
			end
			default:
			begin
				next_state.qstate = scpi_status_pkg::Q_IDLE;
				next_state.qry_ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state.sync1 <= '0;
			state.sync2 <= '0;
			state.cond_prev <= '0;
			state.spoll_prev <= 1'b0;
			state.opc_armed <= 1'b0;
			state.psc <= scpi_status_pkg::PSC_RESET;
			state.sre <= scpi_status_pkg::SRE_RESET;
			state.stb <= '0;
			state.qstate <= scpi_status_pkg::Q_IDLE;
			state.qry_ready <= 1'b1;
			state.resp_valid <= 1'b0;
			state.resp_data <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	// open-drain request line: only ever pulls low
	assign srq_out = 1'b0;
	assign qry_ready = state.qry_ready;
	assign resp_valid = state.resp_valid;
	assign resp_data = state.resp_data;
	assign status_byte = state.stb;
	assign opc_pending = state.opc_armed;
endmodule : scpi_status_reporting

// ### sim/scpi_status_chk.sv
// assertion checker for the status reporting block
`timescale 1ns/100ps
module scpi_status_chk (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic spoll_active,
	input wire logic out_pending,
	input wire logic cmds_done,
	input wire logic ops_done,
	input wire logic cmd_opc,
	input wire logic qry_valid,
	input wire logic [2:0] qry_code,
	input wire logic qry_ready,
	input wire logic resp_valid,
	input wire logic [15:0] resp_data,
	input wire logic [7:0] status_byte,
	input wire logic opc_pending,
	input wire logic [7:0] poll_byte,
	input wire logic poll_valid,
	input wire logic srq_out,
	input wire logic srq_oe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence take_s;
		qry_valid && qry_ready;
	endsequence
	sequence stb_take_s;
		take_s ##0 qry_code == scpi_status_pkg::QRY_STB;
	endsequence
	sequence esr_take_s;
		take_s ##0 qry_code == scpi_status_pkg::QRY_ESR;
	endsequence
	sequence qev_take_s;
		take_s ##0 qry_code == scpi_status_pkg::QRY_QEVENT;
	endsequence
	srq_level_a: assert property (srq_out == 1'b0
		&& (!$rose(srq_oe) || status_byte[6]))
		else $error("request line misdriven");
	stb_unused_a: assert property (status_byte[7] == 1'b0
		&& status_byte[1:0] == 2'b00) else $error("unused stb bit set");
	srq_raise_a: assert property ($rose(status_byte[6])
		|-> ##[0:2] srq_oe)
		else $error("no request after summary rise");
	srq_hold_a: assert property ($fell(srq_oe) |-> poll_valid)
		else $error("request released without poll");
	poll_rqs_a: assert property (poll_valid
		|-> poll_byte[6] == $past(srq_oe))
		else $error("poll byte bit 6 wrong");
	poll_soon_a: assert property ($rose(spoll_active)
		|-> ##[2:4] poll_valid)
		else $error("poll not served at once");
	stb_go_a: assert property (stb_take_s |=> !qry_ready)
		else $error("stb query not held");
	stb_wait_a: assert property (!qry_ready && !cmds_done
		|=> !resp_valid)
		else $error("stb answered before commands done");
	esr_zero_a: assert property (esr_take_s |=> resp_valid
		&& resp_data[15:8] == 8'h00 && resp_data[6] == 1'b0
		&& resp_data[1] == 1'b0) else $error("esr unused bit set");
	ques_zero_a: assert property (qev_take_s |=> resp_valid
		&& (resp_data & ~scpi_status_pkg::QUES_VALID) == 16'h0000)
		else $error("questionable unused bit set");
	opc_done_a: assert property (opc_pending && ops_done && !cmd_opc
		|=> !opc_pending) else $error("opc not completed");
	mav_a: assert property (out_pending ##1 out_pending
		|=> status_byte[4])
		else $error("message available missing");
endmodule : scpi_status_chk
bind scpi_status_reporting scpi_status_chk i_chk (.ref_clk, .nrst,
	.spoll_active, .out_pending, .cmds_done, .ops_done, .cmd_opc,
	.qry_valid, .qry_code, .qry_ready, .resp_valid, .resp_data,
	.status_byte, .opc_pending, .poll_byte, .poll_valid, .srq_out, .srq_oe);

// ### sim/gpib_ctrl_model.sv
// bus controller model that serial-polls the device
`timescale 1ns/100ps
module gpib_ctrl_model #(
	parameter int HOLD = 6
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic srq_n,
	input wire logic poll_req,
	input wire logic auto_poll,
	input wire logic [3:0] dly,
	output logic spoll_active
);
	logic [4:0] cnt;
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt <= 5'h00;
			spoll_active <= 1'b0;
		end
		else if (cnt != 5'h00)
		begin
			cnt <= cnt - 5'h01;
			spoll_active <= cnt > 5'h01 && cnt <= 5'(HOLD + 1);
		end
		else if (poll_req || (auto_poll && !srq_n))
			cnt <= 5'(dly) + 5'(HOLD + 1);
	end
endmodule : gpib_ctrl_model

// ### sim/tb_scpi_status_reporting.sv
// self-checking bench for the status reporting block
`timescale 1ns/100ps
module tb_scpi_status_reporting;
	logic ref_clk, nrst, volt_overload, pll_unlocked, cal_fault, ext_ref_used;
	logic spoll_active, err_queue_nonempty, out_pending, cmds_done, ops_done;
	logic qerr_empty_read, qerr_interrupted, qerr_buffers_full, err_device;
	logic err_exec, err_command, cmd_cls, cmd_preset, cmd_opc, wr_valid;
	logic qry_valid, qry_ready, resp_valid, opc_pending, poll_valid;
	logic srq_out, srq_oe, poll_req, auto_poll, srq_n;
	logic [1:0] wr_code;
	logic [2:0] qry_code;
	logic [3:0] dly, c;
	logic [15:0] wr_data, resp_data, e;
	logic [7:0] status_byte, poll_byte;
	logic [15:0] rq[$];
	logic [7:0] pq[$];
	logic [2:0] qc[7] = '{3'h2, 3'h2, 3'h1, 3'h3, 3'h6, 3'h7, 3'h5};
	logic [15:0] qe[7] = '{16'h0080, 0, 0, 0, 0, 16'h0001, 0};
	logic [15:0] wv[4] = '{16'h00ff, 16'h00ff, 16'hffff, 16'h0000};
	logic [15:0] we[4] = '{16'h003c, 16'h00bd, 16'h0321, 16'h0000};
	logic [2:0] wq[4] = '{3'h1, 3'h3, 3'h6, 3'h7};
	int err_count, cmp_count, n_resp, n, seed;
	assign srq_n = srq_oe ? srq_out : 1'b1;
	scpi_status_reporting i_dut (.ref_clk, .nrst, .volt_overload,
		.pll_unlocked, .cal_fault, .ext_ref_used, .spoll_active,
		.err_queue_nonempty, .out_pending, .cmds_done, .ops_done,
		.qerr_empty_read, .qerr_interrupted, .qerr_buffers_full, .err_device,
		.err_exec, .err_command, .cmd_cls, .cmd_preset, .cmd_opc, .wr_valid,
		.wr_code, .wr_data, .qry_valid, .qry_code, .qry_ready, .resp_valid,
		.resp_data, .status_byte, .opc_pending, .poll_byte, .poll_valid,
		.srq_out, .srq_oe);
	gpib_ctrl_model #(.HOLD(6)) i_ctrl (.ref_clk, .nrst, .srq_n, .poll_req,
		.auto_poll, .dly, .spoll_active);
	task automatic chk(input logic [15:0] s, input logic [15:0] x);
		cmp_count++;
		if (s !== x)
		begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : tick
	task automatic q(input logic [2:0] cd, input logic [15:0] x);
		int m;
		m = n_resp;
		qry_valid <= 1'b1;
		qry_code <= cd;
		rq.push_back(x);
		@(posedge ref_clk);
		qry_valid <= 1'b0;
		repeat (20) if (n_resp == m) @(posedge ref_clk);
	endtask : q
	task automatic wr(input logic [1:0] cd, input logic [15:0] d);
		wr_valid <= 1'b1;
		wr_code <= cd;
		wr_data <= d;
		@(posedge ref_clk);
		wr_valid <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic poll(input logic [7:0] x);
		pq.push_back(x);
		poll_req <= 1'b1;
		@(posedge ref_clk);
		poll_req <= 1'b0;
		tick(15);
	endtask : poll
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		if (resp_valid === 1'b1)
		begin
			n_resp++;
			chk(resp_data, rq.size() > 0 ? rq.pop_front() : 16'hxxxx);
		end
		if (poll_valid === 1'b1)
			chk(16'(poll_byte), pq.size() > 0 ? 16'(pq.pop_front()) : 'x);
	end
	initial
	begin
		tick(20000);
		err_count++;
		print_verdict();
	end
	initial
	begin
		{volt_overload, pll_unlocked, cal_fault, ext_ref_used, ops_done} = '0;
		{err_queue_nonempty, out_pending, qerr_empty_read, qerr_interrupted} = '0;
		{qerr_buffers_full, err_device, err_exec, err_command, cmd_cls} = '0;
		{cmd_preset, cmd_opc, wr_valid, qry_valid, poll_req, auto_poll} = '0;
		{wr_code, qry_code, wr_data, dly} = '0;
		cmds_done = 1'b1;
		seed = 32'h3a5e0f7f;
		nrst = 1'b0;
		tick(3);
		nrst <= 1'b1;
		tick(1);
		for (int i = 0; i < 7; i++) q(qc[i], qe[i]);
		out_pending <= 1'b1;
		err_queue_nonempty <= 1'b1;
		tick(4);
		chk(16'(status_byte), 16'h0014);
		q(scpi_status_pkg::QRY_STB, 16'h0014);
		{out_pending, err_queue_nonempty} <= 2'b00;
		tick(4);
		chk(16'(status_byte), 16'h0000);
		{err_device, err_exec, err_command, qerr_empty_read} <= 4'hf;
		tick(1);
		{err_device, err_command, qerr_empty_read, qerr_interrupted} <= 4'h1;
		tick(1);
		{err_exec, qerr_interrupted, qerr_buffers_full} <= 3'b001;
		tick(1);
		qerr_buffers_full <= 1'b0;
		q(scpi_status_pkg::QRY_ESR, 16'h003c);
		for (int i = 0; i < 3; i++)
		begin
			c = 4'($random(seed));
			{ext_ref_used, cal_fault, pll_unlocked, volt_overload} <= c;
			e = 16'(c[0]) | 16'(c[1]) << 5 | 16'(c[2]) << 8 | 16'(c[3]) << 9;
			tick(6);
			q(scpi_status_pkg::QRY_QCOND, e);
			q(scpi_status_pkg::QRY_QEVENT, e);
			q(scpi_status_pkg::QRY_QEVENT, 16'h0000);
			{ext_ref_used, cal_fault, pll_unlocked, volt_overload} <= 4'h0;
			tick(5);
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(2'(i), wv[i]);
			q(wq[i], we[i]);
		end
		cmd_preset <= 1'b1;
		tick(1);
		cmd_preset <= 1'b0;
		q(scpi_status_pkg::QRY_QENAB, 16'h0000);
		q(scpi_status_pkg::QRY_SRE, 16'h003c);
		cmd_cls <= 1'b1;
		tick(1);
		cmd_cls <= 1'b0;
		wr(scpi_status_pkg::WR_SRE, 16'h0020);
		wr(scpi_status_pkg::WR_ESE, 16'h0020);
		err_command <= 1'b1;
		tick(1);
		err_command <= 1'b0;
		tick(5);
		chk(16'(srq_oe), 16'h0001);
		q(scpi_status_pkg::QRY_STB, 16'h0060);
		chk(16'(srq_oe), 16'h0001);
		poll(8'h60);
		chk(16'(srq_oe), 16'h0000);
		chk(16'(status_byte), 16'h0060);
		poll(8'h20);
		q(scpi_status_pkg::QRY_ESR, 16'h0020);
		tick(3);
		chk(16'(status_byte), 16'h0000);
		err_queue_nonempty <= 1'b1;
		tick(5);
		chk(16'(srq_oe), 16'h0000);
		err_queue_nonempty <= 1'b0;
		auto_poll <= 1'b1;
		dly <= 4'h4;
		pq.push_back(8'h60);
		err_command <= 1'b1;
		tick(1);
		err_command <= 1'b0;
		tick(25);
		chk(16'(srq_oe), 16'h0000);
		auto_poll <= 1'b0;
		q(scpi_status_pkg::QRY_ESR, 16'h0020);
		n = n_resp;
		cmds_done <= 1'b0;
		q(scpi_status_pkg::QRY_STB, 16'h0000);
		chk(16'(n_resp), 16'(n));
		cmds_done <= 1'b1;
		tick(3);
		chk(16'(n_resp), 16'(n + 1));
		cmd_opc <= 1'b1;
		tick(1);
		cmd_opc <= 1'b0;
		tick(3);
		chk(16'(opc_pending), 16'h0001);
		ops_done <= 1'b1;
		tick(3);
		q(scpi_status_pkg::QRY_ESR, 16'h0001);
		ops_done <= 1'b0;
		cmd_opc <= 1'b1;
		tick(1);
		{cmd_opc, cmd_cls} <= 2'b01;
		tick(1);
		cmd_cls <= 1'b0;
		volt_overload <= 1'b1;
		tick(6);
		chk(16'(opc_pending), 16'h0000);
		cmd_cls <= 1'b1;
		tick(1);
		cmd_cls <= 1'b0;
		q(scpi_status_pkg::QRY_QEVENT, 16'h0000);
		q(scpi_status_pkg::QRY_QCOND, 16'h0001);
		// power cycle with the clear setting off: enable must still clear
		wr(scpi_status_pkg::WR_QENAB, 16'h0001);
		nrst <= 1'b0;
		tick(2);
		nrst <= 1'b1;
		tick(1);
		q(scpi_status_pkg::QRY_QENAB, 16'h0000);
		q(scpi_status_pkg::QRY_ESR, 16'h0080);
		tick(3);
		chk(16'(rq.size() + pq.size()), 16'h0000);
		print_verdict();
	end
endmodule : tb_scpi_status_reporting
